/* rtl/ssl_pkg.sv */
// Register map, field positions, reset values, lengths and states for the slave port.
package ssl_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] TX_STATUS_CONTROL_IDX = 4'h0;
  localparam logic [3:0] RX_STATUS_CONTROL_IDX = 4'h1;
  localparam logic [3:0] RECEIVE_DATA_IDX      = 4'h2;
  localparam logic [3:0] TRANSMIT_DATA_IDX     = 4'h3;
  localparam logic [3:0] RATE_DIV_LOW_IDX      = 4'h4;
  localparam logic [3:0] RATE_DIV_HIGH_IDX     = 4'h5;
  localparam logic [3:0] BAUD_CONTROL_IDX      = 4'h6;
  localparam logic [3:0] IRQ_ENABLE_IDX        = 4'h7;
  localparam logic [3:0] IRQ_FLAG_IDX          = 4'h8;

  // Transmit status and control fields.
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int TX_NINE_BIT_ENABLE_BIT  = 6;
  localparam int TRANSMIT_ENABLE_BIT     = 5;
  localparam int CLOCKED_MODE_BIT        = 4;
  localparam int TX_SHIFT_EMPTY_BIT      = 1;
  localparam int TX_NINTH_BIT_BIT        = 0;

  // Receive status and control fields.
  localparam int PORT_ENABLE_BIT         = 7;
  localparam int RX_NINE_BIT_ENABLE_BIT  = 6;
  localparam int SINGLE_RX_ENABLE_BIT    = 5;
  localparam int CONT_RX_ENABLE_BIT      = 4;
  localparam int OVERRUN_FLAG_BIT        = 1;
  localparam int RX_NINTH_BIT_BIT        = 0;

  // Interrupt enable and flag fields.
  localparam int GLOBAL_IRQ_ENABLE_BIT   = 7;
  localparam int PERIPHERAL_IRQ_EN_BIT   = 6;
  localparam int RX_IRQ_BIT              = 5;
  localparam int TX_IRQ_BIT              = 4;

  // Reset values.
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [8:0] DATA9_RESET     = 9'h000;

  // Character lengths in bits.
  localparam logic [3:0] BITS_EIGHT      = 4'h8;
  localparam logic [3:0] BITS_NINE       = 4'h9;

  // Depth of the receive queue.
  localparam logic [1:0] RX_FIFO_DEPTH   = 2'h2;

  // Transmit shifter states.
  typedef enum logic [1:0] {
    SSL_TX_IDLE  = 2'b01,
    SSL_TX_SHIFT = 2'b10
  } ssl_tx_state_t;
endpackage

/* rtl/ssl_top.sv */
// Synchronous slave serial port: registers, shifters and receive queue.
`timescale 1ns/1ps
module ssl_top (
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Register port.
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Serial clock pin.
  input  wire logic       serial_clock_pin_i,
  output logic            serial_clock_pin_o,
  output logic            serial_clock_pin_oe_o,
  // Serial data pin.
  input  wire logic       serial_data_pin_i,
  output logic            serial_data_pin_o,
  output logic            serial_data_pin_oe_o,
  // Wake and service requests.
  output logic            wake_o,
  output logic            irq_o
);

  // Control and data state.
  logic [7:0] tx_ctrl, next_tx_ctrl;
  logic [7:0] rx_ctrl, next_rx_ctrl;
  logic [7:0] rate_lo, next_rate_lo;
  logic [7:0] rate_hi, next_rate_hi;
  logic [7:0] baud_ctrl, next_baud_ctrl;
  logic [7:0] irq_en, next_irq_en;
  logic [7:0] rdata, next_rdata;
  logic [8:0] hold, next_hold;
  logic       hold_full, next_hold_full;
  logic [8:0] tx_shift_register, next_tx_shift_register;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_len, next_tx_len;
  ssl_pkg::ssl_tx_state_t tx_state, next_tx_state;
  logic       dt_out, next_dt_out;
  logic       dt_oe, next_dt_oe;
  logic [8:0] rx_shift_register, next_rx_shift_register;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [8:0] fifo [2];
  logic [8:0] next_fifo [2];
  logic [1:0] fifo_cnt, next_fifo_cnt;
  logic       overrun, next_overrun;
  logic       wake, next_wake;
  logic       irq, next_irq;
  logic       ck_s1, ck_s2, ck_s3;
  logic       dt_s1, dt_s2;

  // Decoded modes.
  logic       port_on, slave, receiver, tx_run, rx_run;
  logic       ck_rise, ck_fall, tx_flag, rx_flag;
  logic [3:0] rx_len;

  // Build a readable status byte with state bits placed in the low field.
  function automatic logic [7:0] with_status(input logic [7:0] ctrl,
                                             input logic       b1,
                                             input logic       b0);
    logic [7:0] v;
    v    = ctrl;
    v[1] = b1;
    v[0] = b0;
    return v;
  endfunction

  // Pin synchronisers and the clock edge history.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end
    else
    begin
      ck_s1 <= serial_clock_pin_i;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= serial_data_pin_i;
      dt_s2 <= dt_s1;
    end
  end

  // Mode decode and edge detection on the synchronised link clock.
  always_comb
  begin
    port_on  = rx_ctrl[ssl_pkg::PORT_ENABLE_BIT];
    slave    = port_on && tx_ctrl[ssl_pkg::CLOCKED_MODE_BIT]
               && !tx_ctrl[ssl_pkg::CLOCK_SOURCE_SELECT_BIT];
    receiver = rx_ctrl[ssl_pkg::SINGLE_RX_ENABLE_BIT]
               || rx_ctrl[ssl_pkg::CONT_RX_ENABLE_BIT];
    // Shifting happens in slave mode alone, on link clock edges seen through the system clock synchronisers.
    tx_run   = slave && !receiver
               && tx_ctrl[ssl_pkg::TRANSMIT_ENABLE_BIT];
    rx_run   = slave && rx_ctrl[ssl_pkg::CONT_RX_ENABLE_BIT];
    ck_rise  = ck_s2 && !ck_s3;
    ck_fall  = !ck_s2 && ck_s3;
    tx_flag  = !hold_full;
    rx_flag  = (fifo_cnt != 2'h0);
    rx_len   = rx_ctrl[ssl_pkg::RX_NINE_BIT_ENABLE_BIT]
               ? ssl_pkg::BITS_NINE : ssl_pkg::BITS_EIGHT;
  end

  // Next-state logic for registers, shifters and the receive queue.
  always_comb
  begin
    next_tx_ctrl   = tx_ctrl;
    next_rx_ctrl   = rx_ctrl;
    next_rate_lo   = rate_lo;
    next_rate_hi   = rate_hi;
    next_baud_ctrl = baud_ctrl;
    next_irq_en    = irq_en;
    next_rdata     = 8'h00;
    next_hold      = hold;
    next_hold_full = hold_full;
    next_tx_shift_register = tx_shift_register;
    next_tx_cnt    = tx_cnt;
    next_tx_len    = tx_len;
    next_tx_state  = tx_state;
    next_dt_out    = dt_out;
    next_rx_shift_register = rx_shift_register;
    next_rx_cnt    = rx_cnt;
    next_fifo      = fifo;
    next_fifo_cnt  = fifo_cnt;
    next_overrun   = overrun;

    // Register reads; reading receive data pops the queue head.
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ssl_pkg::TX_STATUS_CONTROL_IDX:
          next_rdata = with_status(tx_ctrl,
                       (tx_state == ssl_pkg::SSL_TX_IDLE),
                       tx_ctrl[ssl_pkg::TX_NINTH_BIT_BIT]);
        ssl_pkg::RX_STATUS_CONTROL_IDX:
          next_rdata = with_status(rx_ctrl, overrun, fifo[0][8]);
        ssl_pkg::RECEIVE_DATA_IDX:
        begin
          next_rdata = fifo[0][7:0];
          if (rx_flag)
          begin
            next_fifo[0]  = fifo[1];
            next_fifo_cnt = fifo_cnt - 2'h1;
          end
        end
        ssl_pkg::RATE_DIV_LOW_IDX:  next_rdata = rate_lo;
        ssl_pkg::RATE_DIV_HIGH_IDX: next_rdata = rate_hi;
        ssl_pkg::BAUD_CONTROL_IDX:  next_rdata = baud_ctrl;
        ssl_pkg::IRQ_ENABLE_IDX:    next_rdata = irq_en;
        ssl_pkg::IRQ_FLAG_IDX:
        begin
          next_rdata = 8'h00;
          next_rdata[ssl_pkg::RX_IRQ_BIT] = rx_flag;
          next_rdata[ssl_pkg::TX_IRQ_BIT] = tx_flag;
        end
        default: next_rdata = 8'h00;
      endcase
    end

    // Register writes; read-only status bits are kept by hardware.
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        ssl_pkg::TX_STATUS_CONTROL_IDX:
          next_tx_ctrl = {reg_wdata_i[7:2], 1'b0, reg_wdata_i[0]};
        ssl_pkg::RX_STATUS_CONTROL_IDX:
          next_rx_ctrl = {reg_wdata_i[7:2], 2'b00};
        ssl_pkg::TRANSMIT_DATA_IDX:
        begin
          next_hold      = {tx_ctrl[ssl_pkg::TX_NINTH_BIT_BIT],
                            reg_wdata_i};
          next_hold_full = 1'b1;
        end
        ssl_pkg::RATE_DIV_LOW_IDX:  next_rate_lo   = reg_wdata_i;
        ssl_pkg::RATE_DIV_HIGH_IDX: next_rate_hi   = reg_wdata_i;
        ssl_pkg::BAUD_CONTROL_IDX:  next_baud_ctrl = reg_wdata_i;
        ssl_pkg::IRQ_ENABLE_IDX:    next_irq_en    = reg_wdata_i;
        default: ;
      endcase
    end

    // Transmit shifter: load from holding, change on rise, count on fall.
    case (tx_state)
      ssl_pkg::SSL_TX_IDLE:
        if (tx_run && hold_full)
        begin
          next_tx_shift_register = hold;
          next_tx_len    = tx_ctrl[ssl_pkg::TX_NINE_BIT_ENABLE_BIT]
                           ? ssl_pkg::BITS_NINE : ssl_pkg::BITS_EIGHT;
          next_tx_cnt    = 4'h0;
          next_dt_out    = hold[0];
          next_hold_full = reg_wr_i
                           && (reg_addr_i == ssl_pkg::TRANSMIT_DATA_IDX);
          next_tx_state  = ssl_pkg::SSL_TX_SHIFT;
        end
      ssl_pkg::SSL_TX_SHIFT:
        if (!tx_run)
          next_tx_state = ssl_pkg::SSL_TX_IDLE;
        else if (ck_rise && tx_cnt != 4'h0)
          next_dt_out = tx_shift_register[0];
        else if (ck_fall)
        begin
          next_tx_shift_register = {1'b0, tx_shift_register[8:1]};
          next_tx_cnt = tx_cnt + 4'h1;
          if (tx_cnt + 4'h1 == tx_len)
            next_tx_state = ssl_pkg::SSL_TX_IDLE;
        end
      default: next_tx_state = ssl_pkg::SSL_TX_IDLE;
    endcase

    // Receive shifter: sample on the trailing edge, queue whole words.
    if (!rx_run)
      next_rx_cnt = 4'h0;
    else if (ck_fall && !overrun)
    begin
      next_rx_shift_register = {dt_s2, rx_shift_register[8:1]};
      next_rx_cnt = rx_cnt + 4'h1;
      if (rx_cnt + 4'h1 == rx_len)
      begin
        next_rx_cnt = 4'h0;
        if (next_fifo_cnt == ssl_pkg::RX_FIFO_DEPTH)
          next_overrun = 1'b1;
        else
        begin
          next_fifo[next_fifo_cnt[0]] = rx_len == ssl_pkg::BITS_NINE
              ? {dt_s2, rx_shift_register[8:1]}
              : {1'b0, dt_s2, rx_shift_register[8:2]};
          next_fifo_cnt = next_fifo_cnt + 2'h1;
        end
      end
    end

    // Clearing continuous receive ends an overrun and drops a partial word.
    if (!rx_ctrl[ssl_pkg::CONT_RX_ENABLE_BIT])
      next_overrun = 1'b0;

    // Clearing port enable idles the shifters, empties holding and queue, clears overrun.
    if (!port_on)
    begin
      next_hold_full = 1'b0;
      next_tx_state  = ssl_pkg::SSL_TX_IDLE;
      next_tx_cnt    = 4'h0;
      next_dt_out    = 1'b0;
      next_rx_cnt    = 4'h0;
      next_fifo_cnt  = 2'h0;
      next_overrun   = 1'b0;
    end
  end

  // Pin drivers and the wake and service requests.
  always_comb
  begin
    next_dt_oe = tx_run;
    next_wake  = irq_en[ssl_pkg::PERIPHERAL_IRQ_EN_BIT]
                 && ((tx_flag && irq_en[ssl_pkg::TX_IRQ_BIT])
                 || (rx_flag && irq_en[ssl_pkg::RX_IRQ_BIT]));
    next_irq   = next_wake
                 && irq_en[ssl_pkg::GLOBAL_IRQ_ENABLE_BIT];
  end

  // State registers.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_ctrl   <= ssl_pkg::CTRL_RESET;
      rx_ctrl   <= ssl_pkg::CTRL_RESET;
      rate_lo   <= ssl_pkg::CTRL_RESET;
      rate_hi   <= ssl_pkg::CTRL_RESET;
      baud_ctrl <= ssl_pkg::CTRL_RESET;
      irq_en    <= ssl_pkg::CTRL_RESET;
      rdata     <= ssl_pkg::CTRL_RESET;
      hold      <= ssl_pkg::DATA9_RESET;
      hold_full <= 1'b0;
      tx_shift_register <= ssl_pkg::DATA9_RESET;
      tx_cnt    <= 4'h0;
      tx_len    <= ssl_pkg::BITS_EIGHT;
      tx_state  <= ssl_pkg::SSL_TX_IDLE;
      dt_out    <= 1'b0;
      dt_oe     <= 1'b0;
      rx_shift_register <= ssl_pkg::DATA9_RESET;
      rx_cnt    <= 4'h0;
      fifo[0]   <= ssl_pkg::DATA9_RESET;
      fifo[1]   <= ssl_pkg::DATA9_RESET;
      fifo_cnt  <= 2'h0;
      overrun   <= 1'b0;
      wake      <= 1'b0;
      irq       <= 1'b0;
    end
    else
    begin
      tx_ctrl   <= next_tx_ctrl;
      rx_ctrl   <= next_rx_ctrl;
      rate_lo   <= next_rate_lo;
      rate_hi   <= next_rate_hi;
      baud_ctrl <= next_baud_ctrl;
      irq_en    <= next_irq_en;
      rdata     <= next_rdata;
      hold      <= next_hold;
      hold_full <= next_hold_full;
      tx_shift_register <= next_tx_shift_register;
      tx_cnt    <= next_tx_cnt;
      tx_len    <= next_tx_len;
      tx_state  <= next_tx_state;
      dt_out    <= next_dt_out;
      dt_oe     <= next_dt_oe;
      rx_shift_register <= next_rx_shift_register;
      rx_cnt    <= next_rx_cnt;
      fifo[0]   <= next_fifo[0];
      fifo[1]   <= next_fifo[1];
      fifo_cnt  <= next_fifo_cnt;
      overrun   <= next_overrun;
      wake      <= next_wake;
      irq       <= next_irq;
    end
  end

  // The clock pin is never driven in slave mode.
  assign serial_clock_pin_o    = 1'b0;
  assign serial_clock_pin_oe_o = 1'b0;
  assign serial_data_pin_o     = dt_out;
  assign serial_data_pin_oe_o  = dt_oe;
  assign reg_rdata_o           = rdata;
  assign wake_o                = wake;
  assign irq_o                 = irq;

endmodule // ssl_top

/* test/ssl_far_master.sv */
// Behavioural external master that clocks frames through the slave port.
`timescale 1ns/1ps
module ssl_far_master (
  // Pins towards the slave.
  output logic      serial_clock_o,
  output logic      line_o,
  // Slave data driver.
  input  wire logic slave_dt_i,
  input  wire logic slave_oe_i
);
  logic drv_en  = 1'b0;
  logic drv_bit = 1'b0;
  logic hold    = 1'b0;

  // Released line shows the inverse of its last level, never a stale copy.
  assign line_o = slave_oe_i ? slave_dt_i : (drv_en ? drv_bit : hold);

  // Clock stands low outside frames.
  initial serial_clock_o = 1'b0;

  // One frame: data changes on the rise, is sampled on the fall.
  task automatic xfer(input int n, input logic drive, input logic [8:0] w,
                      output logic [8:0] got);
    got = 9'h000;
    drv_en = drive;
    for (int i = 0; i < n; i++)
    begin
      serial_clock_o = 1'b1;
      drv_bit = w[i];
      #200;
      serial_clock_o = 1'b0;
      got[i] = line_o;
      #200;
    end
    hold = ~line_o;
    drv_en = 1'b0;
  endtask
endmodule // ssl_far_master

/* test/ssl_top_checker.sv */
// Concurrent checks on the slave port's top-level pins.
`timescale 1ns/1ps
module ssl_top_checker (
  // Clock and reset.
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  // Serial pins and requests.
  input wire logic       serial_clock_pin_i,
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe_o,
  input wire logic       serial_data_pin_o,
  input wire logic       serial_data_pin_oe_o,
  input wire logic       wake_o,
  input wire logic       irq_o
);
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  clk_drv_off_a: assert property (!serial_clock_pin_oe_o)
    else $error("clock pin driver enabled");
  clk_out_low_a: assert property (!serial_clock_pin_o)
    else $error("clock pin output not low");
  irq_needs_wake_a: assert property (irq_o |-> wake_o)
    else $error("service request without wake");
  periph_off_quiet_a: assert property (reg_wr_i
    && reg_addr_i == ssl_pkg::IRQ_ENABLE_IDX
    && !reg_wdata_i[ssl_pkg::PERIPHERAL_IRQ_EN_BIT]
    |-> ##2 (!wake_o && !irq_o)) else $error("request with enable clear");
  rx_no_drive_a: assert property (reg_wr_i
    && reg_addr_i == ssl_pkg::RX_STATUS_CONTROL_IDX
    && (reg_wdata_i[ssl_pkg::SINGLE_RX_ENABLE_BIT]
    || reg_wdata_i[ssl_pkg::CONT_RX_ENABLE_BIT])
    |-> ##2 !serial_data_pin_oe_o)
    else $error("data driven in receive mode");
  port_off_idle_a: assert property (reg_wr_i
    && reg_addr_i == ssl_pkg::RX_STATUS_CONTROL_IDX
    && !reg_wdata_i[ssl_pkg::PORT_ENABLE_BIT]
    |-> ##2 !serial_data_pin_oe_o) else $error("data driven, port off");
  not_slave_quiet_a: assert property (reg_wr_i
    && reg_addr_i == ssl_pkg::TX_STATUS_CONTROL_IDX
    && (!reg_wdata_i[ssl_pkg::CLOCKED_MODE_BIT]
    || reg_wdata_i[ssl_pkg::CLOCK_SOURCE_SELECT_BIT])
    |-> ##2 !serial_data_pin_oe_o)
    else $error("data driven outside slave mode");
  ext_clock_only_a: assert property ((!reg_wr_i
    && $stable(serial_clock_pin_i)) [*8] |-> $stable(serial_data_pin_o))
    else $error("data moved without external clock");
endmodule // ssl_top_checker

bind ssl_top ssl_top_checker u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .serial_clock_pin_i(serial_clock_pin_i),
  .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
  .serial_data_pin_o(serial_data_pin_o),
  .serial_data_pin_oe_o(serial_data_pin_oe_o),
  .wake_o(wake_o), .irq_o(irq_o)
);

/* test/ssl_top_tb_top.sv */
// Self-checking bench for the synchronous slave serial port.
`timescale 1ns/1ps
module ssl_top_tb_top;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} ssl_row_t;
  logic       clk_sys_i   = 1'b0;
  logic       rst_i       = 1'b1;
  logic [3:0] reg_addr_i  = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       sck, line, dt_o, dt_oe, wake_o, irq_o;
  logic [8:0] got;
  logic [7:0] q;
  int         n_errors = 0;
  int         compares = 0;
  // Storage, read-only and unmapped places, written then read back.
  ssl_row_t rows [8] = '{'{4'h4, 8'h5A, 8'h5A}, '{4'h5, 8'hC3, 8'hC3},
    '{4'h6, 8'h96, 8'h96}, '{4'h7, 8'h30, 8'h30}, '{4'h0, 8'h00, 8'h02},
    '{4'h1, 8'h00, 8'h00}, '{4'h8, 8'h00, 8'h10}, '{4'hF, 8'hFF, 8'h00}};

  // System clock at 20 MHz.
  always #25 clk_sys_i = ~clk_sys_i;

  ssl_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .serial_clock_pin_i(sck), .serial_clock_pin_o(),
    .serial_clock_pin_oe_o(), .serial_data_pin_i(line),
    .serial_data_pin_o(dt_o), .serial_data_pin_oe_o(dt_oe),
    .wake_o(wake_o), .irq_o(irq_o));

  // The master's pins are plain digital; no analog function shares them.
  ssl_far_master far (.serial_clock_o(sck), .line_o(line),
    .slave_dt_i(dt_o), .slave_oe_i(dt_oe));

  // Compares one value and counts the outcome.
  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle register write.
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // One-cycle register read; data taken in the following cycle.
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Waits a fixed number of cycles, then lets updates settle.
  task idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Runs one frame with its link clock edges 17 ns after system clock edges.
  task frame(input int n, input logic drive, input logic [8:0] w);
    @(posedge clk_sys_i);
    #17 far.xfer(n, drive, w, got);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #1000000;
    n_errors++;
    summarize();
  end

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      chk("reg", q, rows[i].e);
    end
    // Two words queued for transmit.
    wr(4'h1, 8'h80);
    wr(4'h0, 8'h30);
    wr(4'h7, 8'h50);
    wr(4'h3, 8'hA5);
    wr(4'h3, 8'h3C);
    idle(4);
    chk("oe", dt_oe, 1'b1);
    rd(4'h8, q);
    chk("flags", q, 8'h00);
    chk("wake", wake_o, 1'b0);
    frame(8, 1'b0, 9'h000);
    chk("tx1", got, 9'h0A5);
    idle(8);
    rd(4'h8, q);
    chk("flags", q, 8'h10);
    chk("wake", wake_o, 1'b1);
    chk("irq", irq_o, 1'b0);
    frame(8, 1'b0, 9'h000);
    chk("tx2", got, 9'h03C);
    wr(4'h7, 8'hD0);
    idle(3);
    chk("irq", irq_o, 1'b1);
    wr(4'h0, 8'h71);
    wr(4'h3, 8'h0F);
    idle(3);
    frame(9, 1'b0, 9'h000);
    chk("tx9", got, 9'h10F);
    // Three words received, the third overruns.
    wr(4'h0, 8'h10);
    wr(4'h7, 8'h60);
    wr(4'h1, 8'h90);
    idle(3);
    frame(8, 1'b1, 9'h05B);
    idle(8);
    chk("wake", wake_o, 1'b1);
    frame(8, 1'b1, 9'h0C4);
    frame(8, 1'b1, 9'h099);
    idle(8);
    rd(4'h1, q);
    chk("rxstat", q, 8'h92);
    rd(4'h2, q);
    chk("rx1", q, 8'h5B);
    rd(4'h2, q);
    chk("rx2", q, 8'hC4);
    rd(4'h1, q);
    chk("rxstat", q, 8'h92);
    wr(4'h1, 8'h80);
    rd(4'h1, q);
    chk("rxstat", q, 8'h80);
    rd(4'h8, q);
    chk("flags", q, 8'h10);
    // Single receive enable alone receives nothing.
    wr(4'h1, 8'hA0);
    frame(8, 1'b1, 9'h011);
    idle(8);
    rd(4'h8, q);
    chk("flags", q, 8'h10);
    wr(4'h1, 8'hD0);
    frame(9, 1'b1, 9'h1A5);
    idle(8);
    rd(4'h1, q);
    chk("rxstat", q, 8'hD1);
    rd(4'h2, q);
    chk("rx9", q, 8'hA5);
    // Internal clock source: nothing shifts, holding stays full.
    wr(4'h1, 8'h80);
    wr(4'h0, 8'hB0);
    wr(4'h3, 8'h55);
    frame(8, 1'b0, 9'h000);
    rd(4'h8, q);
    chk("flags", q, 8'h00);
    chk("oe", dt_oe, 1'b0);
    // Clearing port enable empties the holding register.
    wr(4'h1, 8'h00);
    rd(4'h8, q);
    chk("flags", q, 8'h10);
    // Reset in mid-run.
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    idle(2);
    chk("wake", wake_o, 1'b0);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(4'h1, q);
    chk("rxstat", q, 8'h00);
    rd(4'h8, q);
    chk("flags", q, 8'h10);
    summarize();
  end
endmodule // ssl_top_tb_top
